// file: logic/cfr_params.svh
// constants of the filter routing stage: register offsets, field layout, reset values
// assumes a 32-bit apb slave with byte addresses, one aligned word per register
`ifndef CFR_PARAMS_SVH
`define CFR_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CFR_ADDR_W          12
`define CFR_OFF_ROUTE_LOW   12'h000
`define CFR_OFF_ROUTE_MID   12'h004
`define CFR_OFF_ENABLE      12'h008
`define CFR_OFF_STATUS      12'h00c

// ----------------------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------------------
`define CFR_NUM_FILT        8
`define CFR_SEL_W           4
`define CFR_FILT_W          3
`define CFR_FIFO_CODE       4'hf
`define CFR_ROUTE_RST       16'h0000
`define CFR_ENABLE_RST      8'hff
`define CFR_STAT_FIFO_BIT   4
`define CFR_STAT_FILT_LSB   8
`define CFR_STAT_SEEN_BIT   15

`endif

// file: logic/cfr_pkg.sv
// types shared by the filter routing stage
// assumes cfr_params.svh is on the include path
`include "cfr_params.svh"

package cfr_pkg;

    typedef logic [`CFR_SEL_W-1:0]  cfr_sel_t;
    typedef logic [`CFR_FILT_W-1:0] cfr_filt_t;
    typedef cfr_sel_t [`CFR_NUM_FILT-1:0] cfr_sel_arr_t;

    // all-ones selector sends the message to the receive fifo
    function automatic logic cfr_code_is_fifo(input cfr_sel_t code);
        return code == `CFR_FIFO_CODE;
    endfunction

endpackage

// file: logic/cfr_pick_if.sv
// carrier between the routing register file and the destination picker
// assumes both ends run on the same clock
`timescale 1ns/1ps
`include "cfr_params.svh"

interface cfr_pick_if;
    import cfr_pkg::*;

    logic                     hit_valid;
    logic [`CFR_NUM_FILT-1:0] hit;
    logic [`CFR_NUM_FILT-1:0] enable;
    cfr_sel_arr_t             sel;
    logic                     found;
    cfr_filt_t                filt;
    cfr_sel_t                 code;

    modport owner  (output hit_valid, output hit, output enable, output sel,
                    input found, input filt, input code);
    modport picker (input hit_valid, input hit, input enable, input sel,
                    output found, output filt, output code);
endinterface

// file: logic/cfr_route_pick.sv
// destination picker: qualifies hits by enable and selects the winning filter's code
// assumes hits and selectors are stable in the cycle they are sampled; purely combinational
`timescale 1ns/1ps
`include "cfr_params.svh"

module cfr_route_pick (
    cfr_pick_if.picker pk
);
    import cfr_pkg::*;

    logic [`CFR_NUM_FILT-1:0] qual;

    // ------------------------------------------------------------------------
    // hit qualification
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CFR_NUM_FILT; g++) begin : g_qual
            assign qual[g] = pk.hit_valid & pk.hit[g] & pk.enable[g]; // [R10]
        end
    endgenerate

    // ------------------------------------------------------------------------
    // priority pick, lowest filter number wins when several match
    // ------------------------------------------------------------------------
    always_comb begin
        pk.found = 1'b0;
        pk.filt  = '0;
        pk.code  = '0;
        for (int i = `CFR_NUM_FILT - 1; i >= 0; i--) begin
            if (qual[i]) begin
                pk.found = 1'b1;
                pk.filt  = cfr_filt_t'(i);
                pk.code  = pk.sel[i]; // [R12]
            end
        end
    end

endmodule // cfr_route_pick

// file: logic/cfr_filter_route.sv
// filter routing stage of a can receive path: apb register file plus routed-hit output
// assumes hit_valid/filter_hit come from acceptance logic on clk; apb master on clk
//
// Behaviour
// [R01] filter 3 selector in low bits 15:12
// [R02] all-ones selector routes to receive fifo
// [R03] codes 0..14 route to that buffer
// [R04] filter 2 selector in low bits 11:8
// [R05] filter 1 selector in low bits 7:4
// [R06] filter 0 selector in low bits 3:0
// [R07] filter 6 selector in mid bits 11:8
// [R08] filter 5 selector in mid bits 7:4
// [R09] filter 4 selector in mid bits 3:0
// [R10] disabled filter never accepts or routes
// [R11] filter 7 selector in mid bits 15:12
// [R12] hit routes with selector value at hit
`timescale 1ns/1ps
`include "cfr_params.svh"

module cfr_filter_route #(
    parameter int TAG_W = 8
) (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`CFR_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     hit_valid,
    input  wire logic [`CFR_NUM_FILT-1:0] filter_hit,
    input  wire logic [TAG_W-1:0]         msg_tag,
    output logic                          route_valid,
    output logic                          route_fifo,
    output cfr_pkg::cfr_sel_t             route_dest,
    output cfr_pkg::cfr_filt_t            route_filter,
    output logic      [TAG_W-1:0]         route_tag
);
    import cfr_pkg::*;

    logic [15:0]              route_low_r;
    logic [15:0]              route_mid_r;
    logic [`CFR_NUM_FILT-1:0] filter_accept_enable_r;
    logic                     seen_r;
    logic [31:0]              prdata_nxt;
    logic                     mapped;
    logic                     wr_en;
    logic [31:0]              route_all;
    cfr_sel_arr_t             sel_arr;
    cfr_pick_if               pk ();

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    function automatic logic addr_hit(input logic [`CFR_ADDR_W-1:0] a);
        return a == `CFR_OFF_ROUTE_LOW || a == `CFR_OFF_ROUTE_MID ||
               a == `CFR_OFF_ENABLE    || a == `CFR_OFF_STATUS;
    endfunction

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign mapped  = addr_hit(paddr);
    assign pslverr = psel & penable & ~mapped;
    assign wr_en   = psel & penable & pwrite & mapped;

    // ------------------------------------------------------------------------
    // routing selector and filter enable registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            route_low_r <= `CFR_ROUTE_RST;
        end else if (wr_en && paddr == `CFR_OFF_ROUTE_LOW) begin
            route_low_r <= pwdata[15:0]; // [R01] [R04] [R05] [R06]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            route_mid_r <= `CFR_ROUTE_RST;
        end else if (wr_en && paddr == `CFR_OFF_ROUTE_MID) begin
            route_mid_r <= pwdata[15:0]; // [R07] [R08] [R09] [R11]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            filter_accept_enable_r <= `CFR_ENABLE_RST;
        end else if (wr_en && paddr == `CFR_OFF_ENABLE) begin
            filter_accept_enable_r <= pwdata[`CFR_NUM_FILT-1:0]; // [R10]
        end
    end

    // selector n sits in nibble n of {mid, low}
    assign route_all = {route_mid_r, route_low_r}; // [R01] [R04] [R05] [R06] [R07] [R08] [R09] [R11]
    genvar g;
    generate
        for (g = 0; g < `CFR_NUM_FILT; g++) begin : g_sel
            assign sel_arr[g] = route_all[g*`CFR_SEL_W +: `CFR_SEL_W];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // destination pick
    // ------------------------------------------------------------------------
    assign pk.hit_valid = hit_valid;
    assign pk.hit       = filter_hit;
    assign pk.enable    = filter_accept_enable_r;
    assign pk.sel       = sel_arr;

    cfr_route_pick u_pick (
        .pk (pk)
    );

    // a selector written in the same cycle as a hit takes effect from the next hit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            route_valid  <= 1'b0;
            route_fifo   <= 1'b0;
            route_dest   <= '0;
            route_filter <= '0;
            route_tag    <= '0;
        end else begin
            route_valid <= pk.found; // [R10]
            if (pk.found) begin
                route_fifo   <= cfr_code_is_fifo(pk.code); // [R02]
                route_dest   <= pk.code; // [R03] [R12]
                route_filter <= pk.filt;
                route_tag    <= msg_tag;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            seen_r <= 1'b0;
        end else if (pk.found) begin
            seen_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------------------
    always_comb begin
        prdata_nxt = '0;
        unique case (paddr)
            `CFR_OFF_ROUTE_LOW: prdata_nxt[15:0] = route_low_r;
            `CFR_OFF_ROUTE_MID: prdata_nxt[15:0] = route_mid_r;
            `CFR_OFF_ENABLE:    prdata_nxt[`CFR_NUM_FILT-1:0] = filter_accept_enable_r;
            `CFR_OFF_STATUS: begin
                prdata_nxt[`CFR_SEL_W-1:0] = route_dest;
                prdata_nxt[`CFR_STAT_FIFO_BIT] = cfr_code_is_fifo(route_dest);
                prdata_nxt[`CFR_STAT_FILT_LSB +: `CFR_FILT_W] = route_filter;
                prdata_nxt[`CFR_STAT_SEEN_BIT] = seen_r;
            end
            default:            prdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            prdata <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [15:0]              low_hist_r;
    logic [15:0]              mid_hist_r;
    logic [`CFR_NUM_FILT-1:0] qual_hist_r;
    logic [`CFR_NUM_FILT-1:0] qual_h;
    always_ff @(posedge clk) begin
        low_hist_r  <= route_low_r;
        mid_hist_r  <= route_mid_r;
        qual_hist_r <= qual_h;
    end
    assign qual_h = hit_valid ? (filter_hit & filter_accept_enable_r) : '0;

    f3_field_a: assert property (qual_h == 8'h08 |=> route_valid && route_dest == low_hist_r[15:12]) // [R01]
        else $error("filter 3 routed from wrong field");
    f2_field_a: assert property (qual_h == 8'h04 |=> route_valid && route_dest == low_hist_r[11:8]) // [R04]
        else $error("filter 2 routed from wrong field");
    f1_field_a: assert property (qual_h == 8'h02 |=> route_valid && route_dest == low_hist_r[7:4]) // [R05]
        else $error("filter 1 routed from wrong field");
    f0_field_a: assert property (qual_h == 8'h01 |=> route_valid && route_dest == low_hist_r[3:0]) // [R06]
        else $error("filter 0 routed from wrong field");
    f6_field_a: assert property (qual_h == 8'h40 |=> route_valid && route_dest == mid_hist_r[11:8]) // [R07]
        else $error("filter 6 routed from wrong field");
    f5_field_a: assert property (qual_h == 8'h20 |=> route_valid && route_dest == mid_hist_r[7:4]) // [R08]
        else $error("filter 5 routed from wrong field");
    f4_field_a: assert property (qual_h == 8'h10 |=> route_valid && route_dest == mid_hist_r[3:0]) // [R09]
        else $error("filter 4 routed from wrong field");
    f7_field_a: assert property (qual_h == 8'h80 |=> route_valid && route_dest == mid_hist_r[15:12]) // [R11]
        else $error("filter 7 routed from wrong field");
    low_write_a: assert property ( // [R01] [R04] [R05] [R06]
        psel && penable && pready && pwrite && paddr == `CFR_OFF_ROUTE_LOW |=> route_low_r == $past(pwdata[15:0]))
        else $error("routing low register write lost");
    mid_write_a: assert property ( // [R07] [R08] [R09] [R11]
        psel && penable && pready && pwrite && paddr == `CFR_OFF_ROUTE_MID |=> route_mid_r == $past(pwdata[15:0]))
        else $error("routing mid register write lost");
    fifo_route_a: assert property (route_valid |-> route_fifo == (route_dest == 4'hf)) // [R02]
        else $error("fifo flag disagrees with selector code");
    buf_route_a: assert property (qual_h != 8'h00 ##1 !route_fifo |-> route_valid && route_dest != 4'hf) // [R03]
        else $error("buffer route carries fifo code");
    disabled_drop_a: assert property (qual_h == 8'h00 |=> !route_valid) // [R10]
        else $error("route issued without an enabled hit");
    // winner is worked out from the qualified hits, not from the picker's own output
    hit_order_a: assert property (route_valid |-> $past(hit_valid) && qual_hist_r[route_filter] && // [R12]
            (qual_hist_r & ((8'h01 << route_filter) - 8'h01)) == 8'h00 && route_tag == $past(msg_tag))
        else $error("route not tied to previous hit");
    route_hold_a: assert property (!route_valid |-> $stable(route_dest) && $stable(route_filter) && // [R12]
            $stable(route_tag))
        else $error("route outputs changed without a route");

    fifo_seen_c: cover property (route_valid && route_fifo);
    buf_seen_c: cover property (route_valid && !route_fifo);
    masked_hit_c: cover property (hit_valid && filter_hit != 8'h00 && qual_h == 8'h00);
    multi_hit_c: cover property (qual_h == 8'h09);
    write_at_hit_c: cover property (wr_en && hit_valid);

endmodule // cfr_filter_route

// file: dv/test_cfr_filter_route.sv
// self-checking bench for the filter routing stage
// assumes cfr_params.svh on the include path; drives apb and hit ports directly
`timescale 1ns/1ps
`include "cfr_params.svh"

module test_cfr_filter_route;
    import cfr_pkg::*;

    logic              clk;
    logic              resetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              hit_valid;
    logic [7:0]        filter_hit;
    logic [7:0]        msg_tag;
    logic              route_valid;
    logic              route_fifo;
    cfr_sel_t          route_dest;
    cfr_filt_t         route_filter;
    logic [7:0]        route_tag;
    logic [31:0]       rd;
    logic              er;
    int                bad_count;
    int                n_checks;

    cfr_filter_route cfr_filter_route_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hit_valid(hit_valid), .filter_hit(filter_hit), .msg_tag(msg_tag),
        .route_valid(route_valid), .route_fifo(route_fifo), .route_dest(route_dest),
        .route_filter(route_filter), .route_tag(route_tag));

    always #12.5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ------------------------------------------------------------------------
    // bus and hit drivers
    // ------------------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // wait states are not assumed even though the slave has none today
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic hit(input logic [7:0] v, input logic [7:0] t);
        @(posedge clk);
        hit_valid <= 1'b1; filter_hit <= v; msg_tag <= t;
        @(posedge clk);
        hit_valid <= 1'b0; filter_hit <= 8'h00;
        #1;
    endtask

    task automatic expect_route(input int f, input logic [3:0] s, input logic [7:0] t);
        chk("route_valid", {31'h0, route_valid}, 32'h1);
        chk("route_filter", {29'h0, route_filter}, f[31:0] & 32'h7);
        chk("route_dest", {28'h0, route_dest}, {28'h0, s});
        chk("route_fifo", {31'h0, route_fifo}, {31'h0, s == 4'hf});
        chk("route_tag", {24'h0, route_tag}, {24'h0, t});
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        apb(1'b0, 12'h000, 32'h0); chk("low reset", rd, 32'h0);
        chk("mapped no err", {31'h0, er}, 32'h0);
        apb(1'b0, 12'h00c, 32'h0); chk("status reset", rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0); chk("mid reset", rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0); chk("enable reset", rd, 32'hff);
        apb(1'b1, 12'h7f0, 32'hffff); chk("unmapped err", {31'h0, er}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_fields;
        logic [15:0] lo;
        logic [15:0] mi;
        logic [3:0]  s;
        lo = 16'hf0e1;
        mi = 16'h7c58;
        apb(1'b1, 12'h000, {16'hffff, lo});
        apb(1'b1, 12'h004, {16'hffff, mi});
        apb(1'b0, 12'h000, 32'h0); chk("low readback", rd, {16'h0, lo});
        apb(1'b0, 12'h004, 32'h0); chk("mid readback", rd, {16'h0, mi});
        for (int f = 0; f < 8; f++) begin
            s = (f < 4) ? lo[4*f +: 4] : mi[4*(f-4) +: 4];
            hit(8'h01 << f, 8'h30 + f[7:0]);
            expect_route(f, s, 8'h30 + f[7:0]);
        end
        $display("test fields done");
    endtask

    task automatic t_enable;
        apb(1'b1, 12'h008, 32'h00f7);
        apb(1'b0, 12'h008, 32'h0); chk("enable readback", rd, 32'hf7);
        hit(8'h08, 8'h5a);
        chk("disabled hit", {31'h0, route_valid}, 32'h0);
        hit(8'h0c, 8'h5b);
        expect_route(2, 4'h0, 8'h5b);
        apb(1'b1, 12'h008, 32'h00ff);
        $display("test enable done");
    endtask

    task automatic t_update;
        // a new selector must be used by the very next hit
        apb(1'b1, 12'h000, 32'h0000_d00e);
        hit(8'h09, 8'hc3);
        expect_route(0, 4'he, 8'hc3);
        hit(8'h08, 8'hc4);
        expect_route(3, 4'hd, 8'hc4);
        apb(1'b0, 12'h00c, 32'h0); chk("status", rd, 32'h0000_830d);
        $display("test update done");
    endtask

    task automatic t_midreset;
        // a reset in mid-run drops the registers and the route outputs back to idle
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk("route_valid idle", {31'h0, route_valid}, 32'h0);
        chk("route_tag reset", {24'h0, route_tag}, 32'h0);
        apb(1'b0, 12'h000, 32'h0); chk("low after reset", rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0); chk("enable after reset", rd, 32'hff);
        apb(1'b0, 12'h00c, 32'h0); chk("status after reset", rd, 32'h0);
        hit(8'h08, 8'h77);
        expect_route(3, 4'h0, 8'h77);
        $display("test midreset done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; hit_valid = 1'b0; filter_hit = 8'h00; msg_tag = 8'h00;
        bad_count = 0; n_checks = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_fields;
        t_enable;
        t_update;
        t_midreset;
        final_report;
    end

    initial begin
        #(25 * 20000);
        bad_count++;
        final_report;
    end
endmodule // test_cfr_filter_route
